/* File: hw/far_map.svh */
// offsets, reset values, rate table and timing figures of the ramp block
`ifndef FAR_MAP_SVH
`define FAR_MAP_SVH

// ----------------------------------------
// register word indexes (byte address = 4 * index)
// ----------------------------------------
`define FAR_IDX_ACOU1   8'h62
`define FAR_IDX_CFG1    8'h40
`define FAR_IDX_FLOOR   8'h70
`define FAR_IDX_STAT    8'h71
`define FAR_IDX_NONE    8'hff

// ----------------------------------------
// reset values
// ----------------------------------------
`define FAR_ACOU1_RST   8'h00
`define FAR_FLOOR_RST   24'h000000

// ----------------------------------------
// duty steps per ramp step, by rate code
// ----------------------------------------
`define FAR_INC_0       8'h01
`define FAR_INC_1       8'h02
`define FAR_INC_2       8'h03
`define FAR_INC_3       8'h05
`define FAR_INC_4       8'h08
`define FAR_INC_5       8'h0c
`define FAR_INC_6       8'h18
`define FAR_INC_7       8'h30

// ----------------------------------------
// timing
// ----------------------------------------
`define FAR_CLK_KHZ     10000
`define FAR_RAMP_REF_MS 35000
`define FAR_RAMP_SPAN   171
`define FAR_SLOW_MULT   4
`define FAR_STEP_CYCLES (`FAR_RAMP_REF_MS * `FAR_CLK_KHZ / `FAR_RAMP_SPAN)

`endif

/* File: hw/far_pkg.sv */
// types shared by the ramp configuration block
package far_pkg;

  // ----------------------------------------
  // bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } far_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } far_ahb_rsp_t;

  typedef logic [2:0][7:0] far_duty3_t;

  // ----------------------------------------
  // register layout and states
  // ----------------------------------------
  typedef struct packed {
    logic       floor_duty_select_3;
    logic       floor_duty_select_2;
    logic       floor_duty_select_1;
    logic       sense_sync_all;
    logic       ramp_enable_1;
    logic [2:0] ramp_rate_select_1;
  } far_acou1_t;

  typedef enum logic [1:0] {
    FAR_BUS_IDLE = 2'b00,
    FAR_BUS_RDW  = 2'b01,
    FAR_BUS_RDD  = 2'b11,
    FAR_BUS_WR   = 2'b10
  } far_bus_st_t;

  typedef struct packed {
    far_bus_st_t bus_st;
    logic [7:0]  dp_idx;
    far_acou1_t  acou1;
    logic        lock;
    logic        slow;
    far_duty3_t  floor_duty;
    far_duty3_t  target;
    logic [31:0] hrdata;
    logic [23:0] tick_cnt;
    logic        tick;
  } far_state_t;

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] goal;
  } far_ramp_st_t;

endpackage

/* File: hw/far_ramp.sv */
// stepping ramp for fan drive 1
`timescale 1ns/100ps
`include "far_map.svh"
module far_ramp (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tick,
  input  wire logic       update,
  input  wire logic       enable,
  input  wire logic [2:0] rate,
  input  wire logic [7:0] target_in,
  output logic [7:0]      duty
);

  far_pkg::far_ramp_st_t s;
  far_pkg::far_ramp_st_t next_s;
  logic [7:0]            inc;

  // ----------------------------------------
  // rate table
  // ----------------------------------------
  always_comb begin
    case (rate)
      3'h0:    inc = `FAR_INC_0; // RULE1
      3'h1:    inc = `FAR_INC_1;
      3'h2:    inc = `FAR_INC_2;
      3'h3:    inc = `FAR_INC_3;
      3'h4:    inc = `FAR_INC_4;
      3'h5:    inc = `FAR_INC_5;
      3'h6:    inc = `FAR_INC_6;
      default: inc = `FAR_INC_7;
    endcase
  end

  // ----------------------------------------
  // stepping
  // ----------------------------------------
  always_comb begin
    next_s = s;
    if (update) begin
      next_s.goal = target_in;
    end
    if (!enable) begin
      // no ramp: new duty lands with the update itself
      if (update) begin
        next_s.duty = target_in; // RULE13
      end
    end else if (tick) begin
      // clamp so the last step never overshoots
      if (s.goal > s.duty) begin
        next_s.duty = (s.goal - s.duty > inc) ? s.duty + inc : s.goal; // RULE2
      end else if (s.goal < s.duty) begin
        next_s.duty = (s.duty - s.goal > inc) ? s.duty - inc : s.goal; // RULE2
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign duty = s.duty;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_step_min: assert property ( // RULE1
    tick && enable && rate == 3'h0 && s.goal > s.duty |=> s.duty == $past(s.duty) + 8'h01)
    else $error("slowest rate did not step by one");

  a_step_max: assert property ( // RULE1
    tick && enable && rate == 3'h7 && s.goal > s.duty && s.goal - s.duty > 8'h30
    |=> s.duty == $past(s.duty) + 8'h30)
    else $error("fastest rate did not step by 48");

  a_no_jump: assert property ( // RULE2
    enable && !tick |=> $stable(s.duty))
    else $error("ramped duty moved without a step");

  a_direct_set: assert property ( // RULE13
    update && !enable |=> s.duty == $past(target_in))
    else $error("unramped duty not applied at update");

endmodule

/* File: hw/far_ramp_cfg.sv */
// acoustic ramp configuration register and drive shaping for three fan drives
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "far_map.svh"
// Contract
// RULE1: bits 2:0 pick drive 1 step size: 1,2,3,5,8,12,24,48
// RULE2: with ramping on, drive 1 steps toward the new duty, never jumps
// RULE3: a 33%-to-100% ramp takes 35 s at code 0, scaled by step size
// RULE4: bit 3 set turns on gradual ramping for drive 1
// RULE5: bit 4 set syncs speed senses 2, 3 and 4 to drive 3
// RULE6: bit 4 clear syncs only speed senses 3 and 4 to drive 3
// RULE7: auto mode below threshold: drive 1 off, or at floor when bit 5 set
// RULE8: auto mode below threshold: drive 2 off, or at floor when bit 6 set
// RULE9: auto mode below threshold: drive 3 off, or at floor when bit 7 set
// RULE10: with the lock bit set, writes to this register are ignored
// RULE11: register resets to zero: no ramping, no floors
// RULE12: slow-ramp bit makes every ramp four times longer
// RULE13: ramping off: each new duty applies directly at the next update
module far_ramp_cfg #(
  parameter logic [23:0] STEP_CYCLES = 24'(`FAR_STEP_CYCLES)
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire far_pkg::far_ahb_req_t ahb_req,
  output far_pkg::far_ahb_rsp_t      ahb_rsp,
  input  wire far_pkg::far_duty3_t   calc_duty,
  input  wire logic                  calc_update,
  input  wire logic [2:0]            auto_mode,
  input  wire logic [2:0]            below_hyst,
  output far_pkg::far_duty3_t        fan_drive,
  output logic [2:0]                 speed_sense_sync
);

  far_pkg::far_state_t s;
  far_pkg::far_state_t next_s;
  far_pkg::far_duty3_t want;
  logic [2:0]          floor_sel;
  logic [23:0]         period_m1;
  logic                take;
  logic                ready;
  logic [7:0]          addr_idx;
  logic [31:0]         rd_word;
  logic [7:0]          ramp_duty;

  // ----------------------------------------
  // floor selection per drive
  // ----------------------------------------
  assign floor_sel = {s.acou1.floor_duty_select_3,
                      s.acou1.floor_duty_select_2,
                      s.acou1.floor_duty_select_1};

  // below threshold minus hysteresis in auto mode the calculated duty
  // is replaced by zero or by the programmed floor
  for (genvar i = 0; i < 3; i++) begin : g_floor
    assign want[i] = (auto_mode[i] && below_hyst[i]) ?
                     (floor_sel[i] ? s.floor_duty[i] : 8'h00) : // RULE7 RULE8 RULE9
                     calc_duty[i];
  end

  // ----------------------------------------
  // ramp step period
  // ----------------------------------------
  // the step period changes only with the slow bit; step size sets the ramp time
  assign period_m1 = s.slow ? 24'(`FAR_SLOW_MULT * STEP_CYCLES - 1) // RULE12
                            : STEP_CYCLES - 24'h000001;             // RULE3

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign ready = (s.bus_st != far_pkg::FAR_BUS_RDW);
  assign take  = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

  // anything beyond the low kilobyte maps to an index nobody answers
  assign addr_idx = (ahb_req.haddr[31:10] == 22'h000000) ?
                    ahb_req.haddr[9:2] : `FAR_IDX_NONE;

  always_comb begin
    case (s.dp_idx)
      `FAR_IDX_ACOU1: rd_word = {24'h000000, s.acou1};
      `FAR_IDX_CFG1:  rd_word = {30'h00000000, s.slow, s.lock};
      `FAR_IDX_FLOOR: rd_word = {8'h00, s.floor_duty};
      `FAR_IDX_STAT:  rd_word = {8'h00, s.target[2], s.target[1], ramp_duty};
      default:        rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;

    if (s.tick_cnt >= period_m1) begin
      next_s.tick_cnt = 24'h000000;
      next_s.tick     = 1'b1; // RULE3
    end else begin
      next_s.tick_cnt = s.tick_cnt + 24'h000001;
    end

    if (calc_update) begin
      next_s.target = want;
    end

    case (s.bus_st)
      far_pkg::FAR_BUS_WR: begin
        // lock freezes every config word, the lock itself included
        if (!s.lock) begin // RULE10
          case (s.dp_idx)
            `FAR_IDX_ACOU1: begin
              next_s.acou1 = far_pkg::far_acou1_t'(ahb_req.hwdata[7:0]); // RULE4
            end
            `FAR_IDX_CFG1: begin
              next_s.lock = ahb_req.hwdata[0];
              next_s.slow = ahb_req.hwdata[1];
            end
            `FAR_IDX_FLOOR: begin
              next_s.floor_duty = ahb_req.hwdata[23:0];
            end
            default: begin
            end
          endcase
        end
      end
      far_pkg::FAR_BUS_RDW: begin
        // one wait state so a read never sees a stale word
        next_s.hrdata = rd_word;
        next_s.bus_st = far_pkg::FAR_BUS_RDD;
      end
      default: begin
      end
    endcase

    if (s.bus_st != far_pkg::FAR_BUS_RDW) begin
      if (take) begin
        next_s.dp_idx = addr_idx;
        next_s.bus_st = ahb_req.hwrite ? far_pkg::FAR_BUS_WR : far_pkg::FAR_BUS_RDW;
      end else begin
        next_s.bus_st = far_pkg::FAR_BUS_IDLE;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s            <= '0;
      s.acou1      <= far_pkg::far_acou1_t'(`FAR_ACOU1_RST); // RULE11
      s.floor_duty <= `FAR_FLOOR_RST;
      s.bus_st     <= far_pkg::FAR_BUS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // drive 1 ramp
  // ----------------------------------------
  far_ramp u_ramp (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tick      (s.tick),
    .update    (calc_update),
    .enable    (s.acou1.ramp_enable_1), // RULE4
    .rate      (s.acou1.ramp_rate_select_1),
    .target_in (want[0]),
    .duty      (ramp_duty)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign fan_drive[0] = ramp_duty;
  assign fan_drive[1] = s.target[1];
  assign fan_drive[2] = s.target[2];

  // senses 3 and 4 always follow drive 3; sense 2 only on request
  assign speed_sense_sync = {2'b11, s.acou1.sense_sync_all}; // RULE5 RULE6

  assign ahb_rsp.hrdata    = s.hrdata;
  assign ahb_rsp.hreadyout = ready;
  assign ahb_rsp.hresp     = 1'b0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [24:0] gap;
  logic        gap_clean;

  // cycles since the last step, discarded when the slow bit moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap       <= 25'h0000000;
      gap_clean <= 1'b0;
    end else begin
      gap       <= s.tick ? 25'h0000001 : gap + 25'h0000001;
      gap_clean <= (s.tick || gap_clean) && (next_s.slow == s.slow);
    end
  end

  sequence s_ramp_rate_select_1_wr;
    s.bus_st == far_pkg::FAR_BUS_WR && s.dp_idx == `FAR_IDX_ACOU1;
  endsequence

  sequence s_cut(int i, bit sel);
    calc_update && auto_mode[i] && below_hyst[i] && floor_sel[i] == sel;
  endsequence

  a_step_period: assert property ( // RULE3 RULE12
    s.tick && gap_clean |->
    gap == (s.slow ? 25'(`FAR_SLOW_MULT * STEP_CYCLES) : 25'(STEP_CYCLES)))
    else $error("ramp step period wrong");

  a_enable_wr: assert property ( // RULE4
    s_ramp_rate_select_1_wr ##0 !s.lock |=>
    s.acou1.ramp_enable_1 == $past(ahb_req.hwdata[3]) &&
    s.acou1.ramp_rate_select_1 == $past(ahb_req.hwdata[2:0]))
    else $error("ramp enable or rate not stored");

  a_sync_all: assert property ( // RULE5
    s.acou1.sense_sync_all |-> speed_sense_sync == 3'h7)
    else $error("sense 2 not synced to drive 3");

  a_sync_pair: assert property ( // RULE6
    !s.acou1.sense_sync_all |-> speed_sense_sync == 3'h6)
    else $error("sense sync set wrong");

  a_drive1_off: assert property ( // RULE7
    s_cut(0, 1'b0) ##0 !s.acou1.ramp_enable_1 |=> fan_drive[0] == 8'h00)
    else $error("drive 1 not off below threshold");

  a_drive1_floor: assert property ( // RULE7
    s_cut(0, 1'b1) ##0 !s.acou1.ramp_enable_1 |=>
    fan_drive[0] == $past(s.floor_duty[0]))
    else $error("drive 1 not at floor below threshold");

  a_drive2_off: assert property ( // RULE8
    s_cut(1, 1'b0) |=> fan_drive[1] == 8'h00)
    else $error("drive 2 not off below threshold");

  a_drive2_floor: assert property ( // RULE8
    s_cut(1, 1'b1) |=> fan_drive[1] == $past(s.floor_duty[1]))
    else $error("drive 2 not at floor below threshold");

  a_drive3_floor: assert property ( // RULE9
    s_cut(2, 1'b1) |=> fan_drive[2] == $past(s.floor_duty[2]))
    else $error("drive 3 not at floor below threshold");

  a_drive3_off: assert property ( // RULE9
    s_cut(2, 1'b0) |=> fan_drive[2] == 8'h00)
    else $error("drive 3 not off below threshold");

  a_lock_hold: assert property ( // RULE10
    s_ramp_rate_select_1_wr ##0 s.lock |=> $stable(s.acou1) && s.lock)
    else $error("locked register changed on write");

  a_reset_clear: assert property ( // RULE11
    $rose(hresetn) |-> s.acou1 == 8'h00 && !s.lock && !s.slow)
    else $error("register not cleared by reset");

  a_read_wait: assert property ( // AHB-Lite read wait state, the implementer's own choice
    take && !ahb_req.hwrite |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout)
    else $error("read wait state wrong");

endmodule

/* File: tb/far_fan_model.sv */
// behavioural fans on the three drives with speed sense feedback
`timescale 1ns/100ps
module far_fan_model (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire far_pkg::far_duty3_t fan_drive,
  input  wire logic [2:0]          speed_sense_sync,
  output far_pkg::far_duty3_t      fan_speed
);
  // sense 2 follows drive 2 unless shared on drive 3; rotor lags one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fan_speed <= '0;
    end else begin
      fan_speed[0] <= fan_drive[0];
      fan_speed[1] <= speed_sense_sync[0] ? fan_drive[2] : fan_drive[1];
      fan_speed[2] <= fan_drive[2];
    end
  end
endmodule

/* File: tb/far_ramp_cfg_test.sv */
// self-checking bench of the acoustic ramp configuration block
`timescale 1ns/100ps
module far_ramp_cfg_test;
  localparam int STEP = 20;
  localparam logic [7:0] INC [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
  logic                  hclk;
  logic                  hresetn;
  far_pkg::far_ahb_req_t req;
  far_pkg::far_ahb_rsp_t ahb_rsp;
  far_pkg::far_duty3_t   calc_duty;
  logic                  calc_update;
  logic [2:0]            auto_mode;
  logic [2:0]            below_hyst;
  far_pkg::far_duty3_t   fan_drive;
  logic [2:0]            speed_sense_sync;
  far_pkg::far_duty3_t   fan_speed;
  far_pkg::far_ahb_req_t ahb_req;
  logic [31:0]           rd;
  logic [7:0]            v;
  int                    n;
  int                    fail_count;
  int                    compares;
  int                    cycles;

  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  always_comb begin
    ahb_req        = req;
    ahb_req.hready = ahb_rsp.hreadyout;
  end

  far_ramp_cfg #(.STEP_CYCLES(24'd20)) dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .ahb_req          (ahb_req),
    .ahb_rsp          (ahb_rsp),
    .calc_duty        (calc_duty),
    .calc_update      (calc_update),
    .auto_mode        (auto_mode),
    .below_hyst       (below_hyst),
    .fan_drive        (fan_drive),
    .speed_sense_sync (speed_sense_sync)
  );

  far_fan_model fans (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .fan_drive        (fan_drive),
    .speed_sense_sync (speed_sense_sync),
    .fan_speed        (fan_speed)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready sampled just before the edge, so no race with the slave's update
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    logic r;
    @(posedge hclk);
    req.hsel   <= 1'b1;
    req.htrans <= 2'h2;
    req.haddr  <= a;
    req.hwrite <= wr;
    req.hsize  <= 3'h2;
    do begin
      @(negedge hclk);
      r = ahb_rsp.hreadyout;
      @(posedge hclk);
    end while (r !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    do begin
      @(negedge hclk);
      r  = ahb_rsp.hreadyout;
      rd = ahb_rsp.hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask

  task automatic upd(input logic [23:0] d);
    @(posedge hclk);
    calc_duty   <= d;
    calc_update <= 1'b1;
    @(posedge hclk);
    calc_update <= 1'b0;
    @(negedge hclk);
  endtask

  // waits for drive 1 to move, bounded
  task automatic next_step;
    logic [7:0] prev;
    prev = fan_drive[0];
    n    = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (fan_drive[0] === prev && n < 400);
    v = fan_drive[0];
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    fail_count = 0;
    compares = 0;
    cycles = 0;
    hresetn = 1'b0;
    req = '0;
    calc_duty = '0;
    calc_update = 1'b0;
    auto_mode = 3'h0;
    below_hyst = 3'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;

    ahb(1'b0, 32'h188, 32'h0);
    chk(rd, 32'h0);
    chk({29'h0, speed_sense_sync}, 32'h6);
    chk({8'h00, fan_drive}, 32'h0);
    ahb(1'b1, 32'h188, 32'h10);
    ahb(1'b0, 32'h188, 32'h0);
    chk(rd, 32'h10);
    chk({29'h0, speed_sense_sync}, 32'h7);
    ahb(1'b0, 32'h3fc, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, ahb_rsp.hresp}, 32'h0);
    $display("test reset and sync done");

    // drives 1 and 3 automatic and cold, drive 2 manual
    ahb(1'b1, 32'h1c0, 32'h302010);
    ahb(1'b1, 32'h188, 32'he0);
    auto_mode  <= 3'h5;
    below_hyst <= 3'h7;
    upd(24'h998877);
    chk({8'h00, fan_drive}, 32'h308810);
    ahb(1'b1, 32'h188, 32'h40);
    upd(24'h998877);
    chk({8'h00, fan_drive}, 32'h008800);
    auto_mode <= 3'h2;
    upd(24'h998877);
    chk({8'h00, fan_drive}, 32'h992077);
    ahb(1'b1, 32'h188, 32'h00);
    upd(24'h445566);
    chk({8'h00, fan_drive}, 32'h440066);
    auto_mode <= 3'h0;
    $display("test floor selects done");

    // each rate: first step from zero, then one full step period
    for (int c = 0; c < 8; c++) begin
      ahb(1'b1, 32'h188, {29'h0, c[2:0]});
      upd(24'h000000);
      chk({24'h0, fan_drive[0]}, 32'h0);
      ahb(1'b1, 32'h188, {28'h0, 1'b1, c[2:0]});
      upd(24'h0000ff);
      chk({24'h0, fan_drive[0]}, 32'h0);
      next_step();
      chk({24'h0, v}, {24'h0, INC[c]});
      next_step();
      chk({24'h0, v}, {23'h0, INC[c], 1'b0});
      chk(n, STEP);
    end
    $display("test ramp rates done");

    ahb(1'b1, 32'h100, 32'h2);
    ahb(1'b1, 32'h188, 32'h7);
    upd(24'h000000);
    ahb(1'b1, 32'h188, 32'hf);
    upd(24'h0000ff);
    next_step();
    next_step();
    chk(n, 4 * STEP);
    $display("test slow ramp done");

    ahb(1'b1, 32'h100, 32'h3);
    ahb(1'b1, 32'h188, 32'h55);
    ahb(1'b0, 32'h188, 32'h0);
    chk(rd, 32'hf);
    $display("test lock done");
    report_and_stop();
  end
endmodule
